// ==== logic/eeprom_defs.vh ====
// constants of the serial eeprom command logic
// assumes the includer runs on a 100 MHz clock
`ifndef EEPROM_DEFS_VH
`define EEPROM_DEFS_VH
`define OP_READ          2'h2
`define OP_WRITE         2'h1
`define OP_MISC          2'h0
`define SUB_WRITE_ALL    2'h1
`define SUB_ERASE_ALL    2'h2
`define SUB_PROG_ENABLE  2'h3
`define SUB_PROG_DISABLE 2'h0
`define SELECT_LOW_NS    250
`define CLOCK_NS         10
`define SELECT_LOW_CYC   ((`SELECT_LOW_NS + `CLOCK_NS - 1) / `CLOCK_NS)
`define ERASE_CYC        2000
`define PROGRAM_CYC      2000
`endif

// ==== logic/pin_sync.v ====
// two-flop synchroniser for one pin level
// assumes the pin is asynchronous to clock
`timescale 1ns/1ps
module pin_sync
(
  input  wire clock,
  input  wire nrst,
  input  wire pin,
  output reg  level
);
  reg meta_reg;
  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_reg <= 1'b0;
      level    <= 1'b0;
    end
    else
    begin
      meta_reg <= pin;
      level    <= meta_reg;
    end
  end
endmodule // pin_sync

// ==== logic/serial_eeprom.v ====
// command logic of a serial eeprom: read, write, write-all and enables
// assumes host pins asynchronous; serial clock sampled by clock
`timescale 1ns/1ps
`include "eeprom_defs.vh"
module serial_eeprom
#(
  parameter WIDTH       = 16,
  parameter ADDR_BITS   = 6,
  parameter ERASE_CYC   = `ERASE_CYC,
  parameter PROGRAM_CYC = `PROGRAM_CYC
)
(
  input  wire clock,
  input  wire nrst,
  input  wire chip_select,
  input  wire serial_clock,
  input  wire serial_in,
  output reg  serial_out,
  output reg  serial_out_en,
  output wire busy
);
  localparam DEPTH = 1 << ADDR_BITS;
  localparam CW    = 2 + ADDR_BITS;
  localparam [2:0] S_IDLE = 3'h0, S_CMD = 3'h1, S_DATA = 3'h2, S_READ = 3'h3, S_WAIT = 3'h4,
                   S_DONE = 3'h5;
  localparam [1:0] P_IDLE = 2'h0, P_ERASE = 2'h1, P_PROG = 2'h2;
  localparam [7:0]    CMD_LEN = CW;

  //////////////////////////////////////////////////////////////////////////
  wire cs_s;
  wire sck_s;
  wire si_s;
  pin_sync u_cs  (.clock(clock), .nrst(nrst), .pin(chip_select),  .level(cs_s));
  pin_sync u_sck (.clock(clock), .nrst(nrst), .pin(serial_clock), .level(sck_s));
  pin_sync u_si  (.clock(clock), .nrst(nrst), .pin(serial_in),    .level(si_s));

  reg sck_d_reg;
  reg cs_d_reg;
  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      sck_d_reg <= 1'b0;
      cs_d_reg  <= 1'b0;
    end
    else
    begin
      sck_d_reg <= sck_s;
      cs_d_reg  <= cs_s;
    end
  end
  wire rise    = sck_s & ~sck_d_reg & cs_s;
  wire cs_fall = cs_d_reg & ~cs_s;
  wire cs_rise = cs_s & ~cs_d_reg;

  //////////////////////////////////////////////////////////////////////////
  reg [WIDTH-1:0]     mem [0:DEPTH-1];
  reg [2:0]           state_reg;
  reg [7:0]           cnt_reg;
  reg [CW-1:0]        cmd_reg;
  reg [WIDTH-1:0]     data_reg;
  reg [WIDTH:0]       shift_reg;
  reg [ADDR_BITS-1:0] addr_reg;
  reg                 enabled_reg;
  reg                 pend_reg;
  reg                 pend_all_reg;
  reg [1:0]           pstate_reg;
  reg [15:0]          ptime_reg;
  reg [15:0]          low_cnt_reg;
  reg                 low_ok_reg;
  reg                 status_reg;

  wire [1:0]           op     = cmd_reg[CW-1:CW-2];
  wire [ADDR_BITS-1:0] cmd_ad = cmd_reg[ADDR_BITS-1:0];
  wire [CW-1:0]        cmd_nx = {cmd_reg[CW-2:0], si_s};
  assign busy = (pstate_reg != P_IDLE);

  integer i;
  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg    <= S_IDLE;
      cnt_reg      <= 8'h00;
      cmd_reg      <= {CW{1'b0}};
      data_reg     <= {WIDTH{1'b0}};
      shift_reg    <= {(WIDTH+1){1'b0}};
      addr_reg     <= {ADDR_BITS{1'b0}};
      enabled_reg  <= 1'b0;
      pend_reg     <= 1'b0;
      pend_all_reg <= 1'b0;
    end
    else if (!cs_s)
    begin
      if (cs_fall && state_reg == S_DONE && !busy)
        pend_reg <= 1'b1;
      else
        pend_reg <= 1'b0;
      if (!(cs_fall && state_reg == S_DONE))
        pend_all_reg <= 1'b0;
      state_reg <= S_IDLE;
    end
    else
    begin
      pend_reg <= 1'b0;
      case (state_reg)
        S_IDLE:
        if (rise && si_s && !busy)
        begin
          state_reg <= S_CMD;
          cnt_reg   <= 8'h00;
        end
        S_CMD:
        if (rise)
        begin
          cmd_reg <= cmd_nx;
          cnt_reg <= cnt_reg + 8'h01;
          if (cnt_reg == CMD_LEN - 8'h01)
          begin
            cnt_reg <= 8'h00;
            if (cmd_nx[CW-1:CW-2] == `OP_READ)
            begin
              addr_reg  <= cmd_nx[ADDR_BITS-1:0];
              shift_reg <= {1'b0, mem[cmd_nx[ADDR_BITS-1:0]]};
              state_reg <= S_READ;
            end
            else if (cmd_nx[CW-1:CW-2] == `OP_WRITE)
              state_reg <= S_DATA;
            else if (cmd_nx[CW-3:CW-4] == `SUB_WRITE_ALL)
              state_reg <= S_DATA;
            else
            begin
              if (cmd_nx[CW-3:CW-4] == `SUB_PROG_ENABLE)
                enabled_reg <= 1'b1;
              if (cmd_nx[CW-3:CW-4] == `SUB_PROG_DISABLE)
                enabled_reg <= 1'b0;
              state_reg <= S_WAIT;
            end
          end
        end
        S_DATA:
        if (rise)
        begin
          data_reg <= {data_reg[WIDTH-2:0], si_s};
          cnt_reg  <= cnt_reg + 8'h01;
          if (cnt_reg == WIDTH - 1)
          begin
            state_reg    <= enabled_reg ? S_DONE : S_WAIT;
            pend_all_reg <= (op == `OP_MISC);
          end
        end
        S_READ:
        if (rise)
        begin
          cnt_reg <= cnt_reg + 8'h01;
          if (cnt_reg == WIDTH)
          begin
            cnt_reg   <= 8'h01;
            addr_reg  <= addr_reg + 1'b1;
            shift_reg <= {mem[addr_reg + 1'b1], 1'b0};
          end
          else
            shift_reg <= {shift_reg[WIDTH-1:0], 1'b0};
        end
        default:
          state_reg <= state_reg;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // self-timed erase and program
  reg [ADDR_BITS-1:0] waddr_reg;
  reg [WIDTH-1:0]     wdata_reg;
  reg                 wall_reg;
  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      pstate_reg <= P_IDLE;
      ptime_reg  <= 16'h0000;
      waddr_reg  <= {ADDR_BITS{1'b0}};
      wdata_reg  <= {WIDTH{1'b0}};
      wall_reg   <= 1'b0;
      for (i = 0; i < DEPTH; i = i + 1)
        mem[i] <= {WIDTH{1'b0}};
    end
    else
    begin
      case (pstate_reg)
        P_IDLE:
        // begins at select fall, no clocks needed
        if (pend_reg)
        begin
          pstate_reg <= P_ERASE;
          ptime_reg  <= ERASE_CYC[15:0];
          waddr_reg  <= cmd_ad;
          wdata_reg  <= data_reg;
          wall_reg   <= pend_all_reg;
        end
        P_ERASE:
        if (ptime_reg == 16'h0000)
        begin
          // erase first; whole array on write-all
          for (i = 0; i < DEPTH; i = i + 1)
            if (wall_reg || waddr_reg == i[ADDR_BITS-1:0])
              mem[i] <= {WIDTH{1'b1}};
          pstate_reg <= P_PROG;
          ptime_reg  <= PROGRAM_CYC[15:0];
        end
        else
          ptime_reg <= ptime_reg - 16'h0001;
        P_PROG:
        if (ptime_reg == 16'h0000)
        begin
          for (i = 0; i < DEPTH; i = i + 1)
            if (wall_reg || waddr_reg == i[ADDR_BITS-1:0])
              mem[i] <= wdata_reg;
          pstate_reg <= P_IDLE;
        end
        else
          ptime_reg <= ptime_reg - 16'h0001;
        default:
          pstate_reg <= P_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // select low time and status window
  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      low_cnt_reg <= 16'h0000;
      low_ok_reg  <= 1'b0;
      status_reg  <= 1'b0;
    end
    else
    begin
      if (cs_s)
        low_cnt_reg <= 16'h0000;
      else if (!low_ok_reg)
        low_cnt_reg <= low_cnt_reg + 16'h0001;
      if (cs_fall)
        low_ok_reg <= 1'b0;
      else if (low_cnt_reg >= `SELECT_LOW_CYC - 1)
        low_ok_reg <= 1'b1;
      // status after long enough select low
      if (!cs_s)
        status_reg <= 1'b0;
      else if (cs_rise && low_ok_reg && (busy || pend_reg))
        status_reg <= 1'b1;
      else if (rise && si_s && !busy)
        status_reg <= 1'b0;
    end
  end

  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      serial_out    <= 1'b0;
      serial_out_en <= 1'b0;
    end
    else if (cs_fall || !cs_s)
    begin
      serial_out    <= 1'b0;
      serial_out_en <= 1'b0;
    end
    else if (state_reg == S_READ)
    begin
      serial_out    <= shift_reg[WIDTH];
      serial_out_en <= 1'b1;
    end
    else if (status_reg)
    begin
      serial_out    <= ~busy;
      serial_out_en <= 1'b1;
    end
    else
    begin
      serial_out    <= 1'b0;
      serial_out_en <= 1'b0;
    end
  end
endmodule // serial_eeprom

// ==== tb/eeprom_host.sv ====
// host model: drives select, serial clock and data in
// assumes clock is the 100 MHz bench clock
`timescale 1ns/1ps
module eeprom_host
(
  input  wire clock,
  output reg  chip_select,
  output reg  serial_clock,
  output reg  serial_in,
  input  wire serial_out
);
  initial
  begin
    chip_select = 1'b0;
    serial_clock = 1'b0;
    serial_in = 1'b0;
  end
  // bit set up while clock low, answer taken before the rise
  task bit_io(input logic b, output logic r);
  begin
    serial_in <= b;
    repeat (4) @(posedge clock);
    r = serial_out;
    serial_clock <= 1'b1;
    repeat (4) @(posedge clock);
    serial_clock <= 1'b0;
  end
  endtask
  // frame opened by select, closed by 300 ns low
  task frame(input logic q[$], output logic [32:0] r);
    logic b;
  begin
    r = '0;
    chip_select <= 1'b1;
    foreach (q[i])
    begin
      bit_io(q[i], b);
      r = {r[31:0], b};
    end
    chip_select <= 1'b0;
    repeat (30) @(posedge clock);
  end
  endtask
endmodule // eeprom_host

// ==== tb/eeprom_checker.sv ====
// pin checker of the serial eeprom
// assumes select is held low at least 25 clocks between frames
`timescale 1ns/1ps
module eeprom_checker
#(
  parameter ERASE_CYC   = 20,
  parameter PROGRAM_CYC = 20
)
(
  input wire clock,
  input wire nrst,
  input wire chip_select,
  input wire serial_clock,
  input wire serial_in,
  input wire serial_out,
  input wire serial_out_en,
  input wire busy
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  integer busy_len_reg;
  always @(posedge clock or negedge nrst)
    if (!nrst)
      busy_len_reg <= 0;
    else
      busy_len_reg <= busy ? busy_len_reg + 1 : 0;
  a_release_idle: assert property (!chip_select [*5] |-> !serial_out_en)
    else $error("output driven while deselected");
  a_drive_after_select: assert property ($rose(serial_out_en) |-> $past(chip_select) && $past(chip_select, 2))
    else $error("output driven without select");
  a_busy_shows_low: assert property (serial_out_en && busy |-> !serial_out)
    else $error("status high while busy");
  a_ready_shows_high: assert property ((busy && chip_select) [*6] ##1 !busy |-> ##[0:3] (serial_out_en && serial_out))
    else $error("ready not shown");
  a_status_on_select: assert property ((busy && chip_select) [*6] |-> serial_out_en)
    else $error("status not driven");
  a_cycle_after_deselect: assert property ($rose(busy) |-> !chip_select && !$past(chip_select))
    else $error("cycle began while selected");
  a_erase_then_program: assert property ($fell(busy) |-> $past(busy_len_reg) >= ERASE_CYC + PROGRAM_CYC - 4)
    else $error("cycle too short");
  a_cycle_ends: assert property (busy_len_reg <= ERASE_CYC + PROGRAM_CYC + 4)
    else $error("cycle never ends");
  c_cycle: cover property ($rose(busy));
  c_ready: cover property (serial_out_en && $fell(busy));
  c_read_one: cover property (serial_out_en && !busy && serial_out);
endmodule // eeprom_checker
bind serial_eeprom eeprom_checker #(.ERASE_CYC(ERASE_CYC), .PROGRAM_CYC(PROGRAM_CYC)) chk
  (.clock(clock), .nrst(nrst), .chip_select(chip_select), .serial_clock(serial_clock),
   .serial_in(serial_in), .serial_out(serial_out), .serial_out_en(serial_out_en), .busy(busy));

// ==== tb/tb_top.sv ====
// self-checking bench of the serial eeprom command logic
// assumes host model and checker are compiled before it
`timescale 1ns/1ps
module tb_top;
  logic        clock = 1'b0;
  logic        nrst = 1'b0;
  wire         cs, sk, di, so, so_en, busy;
  // released line reads high, as so is held at 0 while so_en is low
  wire         so_line = so_en ? so : ~so;
  int          n_errors = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  int          mem [64];
  bit          en = 0;
  logic        q [$];
  logic [32:0] r;
  always #5 clock = ~clock;
  eeprom_host host (.clock(clock), .chip_select(cs), .serial_clock(sk), .serial_in(di), .serial_out(so_line));
  serial_eeprom #(.WIDTH(16), .ADDR_BITS(6), .ERASE_CYC(40), .PROGRAM_CYC(40)) uut
    (.clock(clock), .nrst(nrst), .chip_select(cs), .serial_clock(sk), .serial_in(di),
     .serial_out(so), .serial_out_en(so_en), .busy(busy));
  task check(input logic [15:0] got, input logic [15:0] exp);
  begin
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask
  task push(input logic [15:0] v, input int n);
  begin
    for (int i = n - 1; i >= 0; i--)
      q.push_back(v[i]);
  end
  endtask
  task cmd(input logic [1:0] op, input logic [5:0] a);
  begin
    q = {};
    push(16'h1, 1);
    push({14'h0, op}, 2);
    push({10'h0, a}, 6);
  end
  endtask
  task write(input logic [5:0] a, input logic [15:0] v, input bit all);
    int t;
  begin
    // opcode, address, then the data word
    cmd(all ? 2'h0 : 2'h1, all ? {2'h1, 4'($urandom)} : a);
    push(v, 16);
    host.frame(q, r);
    if (en)
    begin
      for (int i = 0; i < 64; i++)
        if (all || i == a) mem[i] = v;
      host.chip_select <= 1'b1;
      repeat (6) @(posedge clock);
      check(so_en, 1);
      check(so, 0);
      for (t = 0; t < 6000 && so !== 1'b1; t++)
        @(posedge clock);
      check(so, 1);
      check(so_en, 1);
      host.chip_select <= 1'b0;
      repeat (30) @(posedge clock);
    end
  end
  endtask
  task read2(input logic [5:0] a);
  begin
    cmd(2'h2, a);
    repeat (33) q.push_back(1'($urandom));
    host.frame(q, r);
    check(r[32], 0);
    check(r[31:16], 16'(mem[a]));
    check(r[15:0], 16'(mem[(a + 1) % 64]));
  end
  endtask
  task set_enable(input bit v);
  begin
    cmd(2'h0, v ? 6'h30 : 6'h00);
    host.frame(q, r);
    en = v;
  end
  endtask
  task results;
  begin
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  end
  endtask
  always @(posedge clock)
  begin
    cycles++;
    if (cycles > 40000)
    begin
      n_errors++;
      results();
    end
  end
  initial
  begin
    foreach (mem[i]) mem[i] = 0;
    r = $urandom(60);
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    repeat (3) @(posedge clock);
    write(6'h05, 16'($urandom), 0);
    write(6'h00, 16'($urandom), 1);
    read2(6'h05);
    $display("test disabled done");
    set_enable(1);
    write(6'h3f, 16'($urandom), 0);
    write(6'h00, 16'($urandom), 0);
    read2(6'h3f);
    $display("test write wrap done");
    // whole array then one word over it
    write(6'h00, 16'($urandom), 1);
    write(6'h15, 16'($urandom), 0);
    read2(6'h14);
    $display("test write all done");
    set_enable(0);
    write(6'h14, 16'($urandom), 0);
    read2(6'h14);
    $display("test disable done");
    results();
  end
endmodule // tb_top
